// ===== verilog/ioxe_exec.sv
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
// Operation
// RULE1 - port drive write copies accumulator into the selected drive register
// RULE2 - wakeup write copies accumulator into the selected wakeup register
// RULE3 - wakeup read loads accumulator with the selected wakeup register
// RULE4 - each pull-up register is writable from and readable into accumulator
// RULE5 - shift read puts high nibble in B, low nibble in accumulator
// RULE6 - shift write loads high nibble from B, low nibble from accumulator
// RULE7 - serial start clears the done flag and launches a transfer
// RULE8 - completion test skips and clears flag when irq enable low, flag set
// RULE9 - completion test with serial irq enable set behaves as no-op
// RULE10 - serial control register readable and writable via accumulator
// RULE11 - oscillator select switches main clock to the internal rc source
// RULE12 - clock source write copies only accumulator bit zero
// RULE13 - clock mode register readable and writable via accumulator
// RULE14 - other transfers keep carry and never skip
// RULE15 - skipped instruction is fetched but has no effect
module ioxe_exec (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        instr_valid_i,
  input  wire logic [9:0]  opcode_i,
  input  wire logic [3:0]  acc_i,
  input  wire logic [3:0]  breg_i,
  input  wire logic [3:0]  interrupt_ctl_two_i,
  output logic             acc_wr_o,
  output logic [3:0]       acc_data_o,
  output logic             breg_wr_o,
  output logic [3:0]       breg_data_o,
  output logic             skip_o,
  output logic [15:0]      port_drive_cfg_o,
  output logic [3:0]       port_output_cfg_aux_o,
  output logic [15:0]      key_wakeup_cfg_o,
  output logic [11:0]      pullup_cfg_o,
  output logic [3:0]       serial_ctl_o,
  output logic [3:0]       clock_mode_ctl_o,
  output logic             clock_source_ctl_o,
  output logic             rc_osc_sel_o,
  output logic             sclk_o,
  output logic             sout_o,
  input  wire logic        sin_i,
  output logic             irq_o
);
  import ioxe_pkg::*;

  logic [3:0] slot_reg [NUM_SLOTS];
  logic [3:0] slot_next [NUM_SLOTS];
  logic       clksrc_reg, clksrc_next, rcsel_reg, rcsel_next;
  logic       pend_reg, pend_next, done_flag_reg, done_flag_next;
  logic       accwr_reg, accwr_next, bwr_reg, bwr_next, skip_reg, skip_next;
  logic [3:0] accd_reg, accd_next, bd_reg, bd_next;
  logic       ser_load, ser_start, ser_busy, ser_done, sin_sync, take;
  logic [7:0] ser_shift;
  logic [3:0] sel;
  logic       sel_wr, sel_rd;

  ioxe_sync u_sin_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .din_i     (sin_i),
    .dout_o    (sin_sync)
  );

  // apb state declared early, the serial engine reads the divider
  logic [7:0]          div_reg, div_next;
  logic [IRQ_BITS-1:0] stat_reg, stat_next, mask_reg, mask_next;
  logic [31:0]         rdata_reg, rdata_next;
  logic                err_reg, err_next;

  ioxe_serial #(
    .BITS (SER_BITS)
  ) u_serial (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .load_i      (ser_load),
    .load_data_i ({breg_i, acc_i}),
    .start_i     (ser_start),
    .div_i       (div_reg),
    .sin_i       (sin_sync),
    .shift_o     (ser_shift),
    .busy_o      (ser_busy),
    .done_o      (ser_done),
    .sclk_o      (sclk_o),
    .sout_o      (sout_o)
  );

  // an instruction counts unless a pending skip swallows it
  assign take = instr_valid_i && !pend_reg; // [RULE15]

  // map plain nibble transfers onto a slot index
  always_comb begin
    sel    = 4'h0;
    sel_wr = 1'b0;
    sel_rd = 1'b0;
    unique case (opcode_i)
      OP_WR_DRIVE0:  begin sel = 4'h0;        sel_wr = 1'b1; end // [RULE1]
      OP_WR_DRIVE1:  begin sel = 4'h1;        sel_wr = 1'b1; end // [RULE1]
      OP_WR_DRIVE2:  begin sel = 4'h2;        sel_wr = 1'b1; end // [RULE1]
      OP_WR_DRIVE3:  begin sel = 4'h3;        sel_wr = 1'b1; end // [RULE1]
      OP_WR_AUX:     begin sel = SLOT_AUX;    sel_wr = 1'b1; end // [RULE1]
      OP_WR_KEY0:    begin sel = SLOT_KEY0;   sel_wr = 1'b1; end // [RULE2]
      OP_WR_KEY1:    begin sel = 4'h6;        sel_wr = 1'b1; end // [RULE2]
      OP_WR_KEY2:    begin sel = 4'h7;        sel_wr = 1'b1; end // [RULE2]
      OP_WR_KEYX:    begin sel = SLOT_KEYX;   sel_wr = 1'b1; end // [RULE2]
      OP_RD_KEY0:    begin sel = SLOT_KEY0;   sel_rd = 1'b1; end // [RULE3]
      OP_RD_KEY1:    begin sel = 4'h6;        sel_rd = 1'b1; end // [RULE3]
      OP_RD_KEY2:    begin sel = 4'h7;        sel_rd = 1'b1; end // [RULE3]
      OP_RD_KEYX:    begin sel = SLOT_KEYX;   sel_rd = 1'b1; end // [RULE3]
      OP_WR_PULL0:   begin sel = SLOT_PULL0;  sel_wr = 1'b1; end // [RULE4]
      OP_WR_PULL1:   begin sel = 4'hA;        sel_wr = 1'b1; end // [RULE4]
      OP_WR_PULL2:   begin sel = 4'hB;        sel_wr = 1'b1; end // [RULE4]
      OP_RD_PULL0:   begin sel = SLOT_PULL0;  sel_rd = 1'b1; end // [RULE4]
      OP_RD_PULL1:   begin sel = 4'hA;        sel_rd = 1'b1; end // [RULE4]
      OP_RD_PULL2:   begin sel = 4'hB;        sel_rd = 1'b1; end // [RULE4]
      OP_WR_SERCTL:  begin sel = SLOT_SERCTL; sel_wr = 1'b1; end // [RULE10]
      OP_RD_SERCTL:  begin sel = SLOT_SERCTL; sel_rd = 1'b1; end // [RULE10]
      OP_WR_CLKMODE: begin sel = SLOT_CLKMODE; sel_wr = 1'b1; end // [RULE13]
      OP_RD_CLKMODE: begin sel = SLOT_CLKMODE; sel_rd = 1'b1; end // [RULE13]
      default:       begin sel = 4'h0; end
    endcase
  end

  assign ser_load  = take && (opcode_i == OP_WR_SHIFT);  // [RULE6]
  assign ser_start = take && (opcode_i == OP_SER_START); // [RULE7]

  // execution: results are registered, so they appear one cycle later
  always_comb begin
    for (int i = 0; i < NUM_SLOTS; i++) begin
      slot_next[i] = slot_reg[i];
    end
    clksrc_next    = clksrc_reg;
    rcsel_next     = rcsel_reg;
    pend_next      = pend_reg;
    done_flag_next = done_flag_reg;
    accwr_next     = 1'b0;
    accd_next      = accd_reg;
    bwr_next       = 1'b0;
    bd_next        = bd_reg;
    skip_next      = 1'b0;
    if (instr_valid_i && pend_reg) begin
      pend_next = 1'b0; // [RULE15]
    end
    if (take) begin
      if (sel_wr) begin
        slot_next[sel] = acc_i; // [RULE1] [RULE2] [RULE4] [RULE10] [RULE13]
      end
      if (sel_rd) begin
        accwr_next = 1'b1; // [RULE3] [RULE4] [RULE10] [RULE13]
        accd_next  = slot_reg[sel];
      end
      unique case (opcode_i)
        OP_RD_SHIFT: begin
          accwr_next = 1'b1; // [RULE5]
          accd_next  = ser_shift[3:0];
          bwr_next   = 1'b1;
          bd_next    = ser_shift[7:4];
        end
        OP_SER_START: begin
          done_flag_next = 1'b0; // [RULE7]
        end
        OP_SER_TEST: begin
          // with the serial irq enabled the flag belongs to the irq path
          if (!interrupt_ctl_two_i[SER_IRQ_BIT] && done_flag_reg) begin // [RULE8] [RULE9]
            done_flag_next = 1'b0;
            pend_next      = 1'b1;
            skip_next      = 1'b1;
          end
        end
        OP_RC_SELECT: rcsel_next  = 1'b1;     // [RULE11]
        OP_WR_CLKSRC: clksrc_next = acc_i[0]; // [RULE12]
        default: begin
          // other transfers never touch skip or carry [RULE14]
        end
      endcase
    end
    // completion wins over a same-cycle clear
    if (ser_done) begin
      done_flag_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        slot_reg[i] <= NIBBLE_RESET;
      end
      clksrc_reg    <= 1'b0;
      rcsel_reg     <= 1'b0;
      pend_reg      <= 1'b0;
      done_flag_reg <= 1'b0;
      accwr_reg     <= 1'b0;
      accd_reg      <= 4'h0;
      bwr_reg       <= 1'b0;
      bd_reg        <= 4'h0;
      skip_reg      <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        slot_reg[i] <= slot_next[i];
      end
      clksrc_reg    <= clksrc_next;
      rcsel_reg     <= rcsel_next;
      pend_reg      <= pend_next;
      done_flag_reg <= done_flag_next;
      accwr_reg     <= accwr_next;
      accd_reg      <= accd_next;
      bwr_reg       <= bwr_next;
      bd_reg        <= bd_next;
      skip_reg      <= skip_next;
    end
  end

  // apb slave: zero wait states, error on unmapped words
  logic apb_acc, apb_wr, apb_rd;
  assign apb_acc = psel_i && penable_i;
  assign apb_wr  = apb_acc && pwrite_i;
  assign apb_rd  = apb_acc && !pwrite_i;

  always_comb begin
    div_next   = div_reg;
    mask_next  = mask_reg;
    stat_next  = stat_reg;
    rdata_next = 32'h0000_0000;
    err_next   = 1'b0;
    if (psel_i && !penable_i) begin
      unique case (paddr_i)
        ADDR_VIEW0:    rdata_next = {16'h0000, slot_reg[3], slot_reg[2], slot_reg[1],
                                     slot_reg[0]};
        ADDR_VIEW1:    rdata_next = {12'h000, slot_reg[8], slot_reg[7], slot_reg[6],
                                     slot_reg[5], slot_reg[4]};
        ADDR_VIEW2:    rdata_next = {10'h000, rcsel_reg, clksrc_reg, slot_reg[13],
                                     slot_reg[12], slot_reg[11], slot_reg[10], slot_reg[9]};
        ADDR_SHIFT:    rdata_next = {22'h00_0000, ser_busy, done_flag_reg, ser_shift};
        ADDR_BITDIV:   rdata_next = {24'h00_0000, div_reg};
        ADDR_IRQ_STAT: rdata_next = {30'h0000_0000, stat_reg};
        ADDR_IRQ_MASK: rdata_next = {30'h0000_0000, mask_reg};
        default:       err_next   = 1'b1;
      endcase
    end else if (apb_acc) begin
      rdata_next = rdata_reg;
      err_next   = err_reg;
    end
    if (apb_wr && paddr_i == ADDR_BITDIV) begin
      div_next = pwdata_i[7:0];
    end
    if (apb_wr && paddr_i == ADDR_IRQ_MASK) begin
      mask_next = pwdata_i[IRQ_BITS-1:0];
    end
    if (apb_rd && paddr_i == ADDR_IRQ_STAT) begin
      stat_next = '0;
    end
    // events set after the read clear so none in the access cycle is lost; one in the setup cycle is cleared unread
    if (ser_done) begin
      stat_next[IRQ_SER_DONE] = 1'b1;
    end
    if (skip_next) begin
      stat_next[IRQ_SKIP] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg   <= BITDIV_RESET;
      mask_reg  <= '0;
      stat_reg  <= '0;
      rdata_reg <= 32'h0000_0000;
      err_reg   <= 1'b0;
    end else begin
      div_reg   <= div_next;
      mask_reg  <= mask_next;
      stat_reg  <= stat_next;
      rdata_reg <= rdata_next;
      err_reg   <= err_next;
    end
  end

  assign prdata_o  = rdata_reg;
  assign pready_o  = 1'b1;
  assign pslverr_o = apb_acc && err_reg;
  assign irq_o     = |(stat_reg & mask_reg);

  assign acc_wr_o              = accwr_reg;
  assign acc_data_o            = accd_reg;
  assign breg_wr_o             = bwr_reg;
  assign breg_data_o           = bd_reg;
  assign skip_o                = skip_reg;
  assign port_drive_cfg_o      = {slot_reg[3], slot_reg[2], slot_reg[1], slot_reg[0]};
  assign port_output_cfg_aux_o = slot_reg[SLOT_AUX];
  assign key_wakeup_cfg_o      = {slot_reg[8], slot_reg[7], slot_reg[6], slot_reg[5]};
  assign pullup_cfg_o          = {slot_reg[11], slot_reg[10], slot_reg[9]};
  assign serial_ctl_o          = slot_reg[SLOT_SERCTL];
  assign clock_mode_ctl_o      = slot_reg[SLOT_CLKMODE];
  assign clock_source_ctl_o    = clksrc_reg;
  assign rc_osc_sel_o          = rcsel_reg;

  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_drive_wr;
    take && opcode_i == OP_WR_DRIVE2 |=> port_drive_cfg_o[11:8] == $past(acc_i);
  endproperty
  a_drive_wr: assert property (p_drive_wr) else $error("drive write lost"); // [RULE1]
  property p_key_wr;
    take && opcode_i == OP_WR_KEYX |=> slot_reg[SLOT_KEYX] == $past(acc_i);
  endproperty
  a_key_wr: assert property (p_key_wr) else $error("wakeup write lost"); // [RULE2]
  property p_key_rd;
    take && opcode_i == OP_RD_KEY1 |=> acc_wr_o && acc_data_o == key_wakeup_cfg_o[7:4];
  endproperty
  a_key_rd: assert property (p_key_rd) else $error("wakeup read wrong"); // [RULE3]
  property p_pull_rt;
    take && opcode_i == OP_WR_PULL1 ##1 take && opcode_i == OP_RD_PULL1
      |=> acc_wr_o && acc_data_o == $past(acc_i, 2);
  endproperty
  a_pull_rt: assert property (p_pull_rt) else $error("pull-up round trip"); // [RULE4]
  property p_shift_rd;
    take && opcode_i == OP_RD_SHIFT
      |=> breg_wr_o && acc_wr_o && {breg_data_o, acc_data_o} == $past(ser_shift);
  endproperty
  a_shift_rd: assert property (p_shift_rd) else $error("shift read split"); // [RULE5]
  property p_shift_wr;
    ser_load |=> ser_shift == {$past(breg_i), $past(acc_i)};
  endproperty
  a_shift_wr: assert property (p_shift_wr) else $error("shift write split"); // [RULE6]
  property p_start;
    ser_start && !ser_done |=> !done_flag_reg && ser_busy;
  endproperty
  a_start: assert property (p_start) else $error("start failed"); // [RULE7]
  property p_test_skip;
    take && opcode_i == OP_SER_TEST && !interrupt_ctl_two_i[SER_IRQ_BIT] && done_flag_reg
      && !ser_done |=> skip_o && !done_flag_reg ##1 !skip_o;
  endproperty
  a_test_skip: assert property (p_test_skip) else $error("test skip"); // [RULE8]
  property p_test_nop;
    take && opcode_i == OP_SER_TEST && interrupt_ctl_two_i[SER_IRQ_BIT]
      |=> !skip_o && done_flag_reg == $past(done_flag_reg | ser_done);
  endproperty
  a_test_nop: assert property (p_test_nop) else $error("test not a no-op"); // [RULE9]
  property p_rc;
    take && opcode_i == OP_RC_SELECT |=> rc_osc_sel_o;
  endproperty
  a_rc: assert property (p_rc) else $error("rc select"); // [RULE11]
  property p_clksrc;
    take && opcode_i == OP_WR_CLKSRC |=> clock_source_ctl_o == $past(acc_i[0]);
  endproperty
  a_clksrc: assert property (p_clksrc) else $error("clock source"); // [RULE12]
  property p_noskip;
    take && opcode_i != OP_SER_TEST |=> !skip_o;
  endproperty
  a_noskip: assert property (p_noskip) else $error("spurious skip"); // [RULE14]
  property p_suppress;
    instr_valid_i && pend_reg |=> !acc_wr_o && !breg_wr_o && !skip_o
      && $stable(port_drive_cfg_o) && $stable(clock_source_ctl_o);
  endproperty
  a_suppress: assert property (p_suppress) else $error("skipped op acted"); // [RULE15]

  c_skip:  cover property (skip_o ##1 instr_valid_i);
  c_done:  cover property (ser_start ##[1:1000] ser_done);
  c_irq:   cover property ($rose(irq_o));
  c_shift: cover property (ser_load ##1 ser_start);
endmodule : ioxe_exec

// ===== verilog/ioxe_pkg.sv
package ioxe_pkg;
  // instruction word encodings
  localparam logic [9:0] OP_WR_DRIVE0   = 10'h228;
  localparam logic [9:0] OP_WR_DRIVE1   = 10'h229;
  localparam logic [9:0] OP_WR_DRIVE2   = 10'h22A;
  localparam logic [9:0] OP_WR_DRIVE3   = 10'h22B;
  localparam logic [9:0] OP_WR_AUX      = 10'h2A8;
  localparam logic [9:0] OP_WR_KEY0     = 10'h21B;
  localparam logic [9:0] OP_RD_KEY0     = 10'h256;
  localparam logic [9:0] OP_WR_KEY1     = 10'h214;
  localparam logic [9:0] OP_RD_KEY1     = 10'h259;
  localparam logic [9:0] OP_WR_KEY2     = 10'h215;
  localparam logic [9:0] OP_RD_KEY2     = 10'h25A;
  localparam logic [9:0] OP_WR_PULL0    = 10'h22D;
  localparam logic [9:0] OP_RD_PULL0    = 10'h257;
  localparam logic [9:0] OP_WR_PULL1    = 10'h22E;
  localparam logic [9:0] OP_RD_PULL1    = 10'h25E;
  localparam logic [9:0] OP_WR_PULL2    = 10'h22F;
  localparam logic [9:0] OP_RD_PULL2    = 10'h25F;
  localparam logic [9:0] OP_WR_KEYX     = 10'h20A;
  localparam logic [9:0] OP_RD_KEYX     = 10'h24A;
  localparam logic [9:0] OP_RD_SHIFT    = 10'h278;
  localparam logic [9:0] OP_WR_SHIFT    = 10'h238;
  localparam logic [9:0] OP_SER_START   = 10'h29E;
  localparam logic [9:0] OP_SER_TEST    = 10'h288;
  localparam logic [9:0] OP_RD_SERCTL   = 10'h242;
  localparam logic [9:0] OP_WR_SERCTL   = 10'h202;
  localparam logic [9:0] OP_RC_SELECT   = 10'h29B;
  localparam logic [9:0] OP_WR_CLKSRC   = 10'h209;
  localparam logic [9:0] OP_RD_CLKMODE  = 10'h252;
  localparam logic [9:0] OP_WR_CLKMODE  = 10'h216;
  // nibble register file slots
  localparam int         NUM_SLOTS      = 14;
  localparam logic [3:0] SLOT_AUX       = 4'h4;
  localparam logic [3:0] SLOT_KEY0      = 4'h5;
  localparam logic [3:0] SLOT_KEYX      = 4'h8;
  localparam logic [3:0] SLOT_PULL0     = 4'h9;
  localparam logic [3:0] SLOT_SERCTL    = 4'hC;
  localparam logic [3:0] SLOT_CLKMODE   = 4'hD;
  localparam logic [3:0] NIBBLE_RESET   = 4'h0;
  localparam int         SER_IRQ_BIT    = 3;
  // apb map
  localparam logic [7:0] ADDR_VIEW0     = 8'h00;
  localparam logic [7:0] ADDR_VIEW1     = 8'h04;
  localparam logic [7:0] ADDR_VIEW2     = 8'h08;
  localparam logic [7:0] ADDR_SHIFT     = 8'h0C;
  localparam logic [7:0] ADDR_BITDIV    = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h18;
  localparam logic [7:0] BITDIV_RESET   = 8'h04;
  localparam int         IRQ_BITS       = 2;
  localparam int         IRQ_SER_DONE   = 0;
  localparam int         IRQ_SKIP       = 1;
  localparam int         SER_BITS       = 8;
endpackage : ioxe_pkg

// ===== verilog/ioxe_sync.sv
`timescale 1ns/1ps
module ioxe_sync (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic din_i,
  output logic      dout_o
);
  logic s1_reg, s2_reg, s3_reg, out_reg, out_next;

  // accept a new level only once two late stages agree
  always_comb begin
    out_next = (s2_reg == s3_reg) ? s3_reg : out_reg;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg  <= 1'b1;
      s2_reg  <= 1'b1;
      s3_reg  <= 1'b1;
      out_reg <= 1'b1;
    end else begin
      s1_reg  <= din_i;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign dout_o = out_reg;
endmodule : ioxe_sync

// ===== verilog/ioxe_serial.sv
`timescale 1ns/1ps
module ioxe_serial
  import ioxe_pkg::*;
#(
  parameter int BITS = ioxe_pkg::SER_BITS
) (
  input  wire logic            ref_clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            load_i,
  input  wire logic [BITS-1:0] load_data_i,
  input  wire logic            start_i,
  input  wire logic [7:0]      div_i,
  input  wire logic            sin_i,
  output logic [BITS-1:0]      shift_o,
  output logic                 busy_o,
  output logic                 done_o,
  output logic                 sclk_o,
  output logic                 sout_o
);
  logic [BITS-1:0] shift_reg, shift_next;
  logic [7:0]      cnt_reg, cnt_next;
  logic [3:0]      bit_reg, bit_next;
  logic            busy_reg, busy_next, sclk_reg, sclk_next, done_reg, done_next;

  // half-period timer toggles the clock; msb goes out, sample lands in lsb
  always_comb begin
    shift_next = shift_reg;
    cnt_next   = cnt_reg;
    bit_next   = bit_reg;
    busy_next  = busy_reg;
    sclk_next  = sclk_reg;
    done_next  = 1'b0;
    if (start_i) begin
      busy_next = 1'b1;
      cnt_next  = 8'h00;
      bit_next  = 4'h0;
      sclk_next = 1'b1;
    end else if (busy_reg) begin
      if (cnt_reg >= div_i) begin
        cnt_next  = 8'h00;
        sclk_next = ~sclk_reg;
        if (!sclk_reg) begin
          // rising edge: capture and count the bit
          shift_next = {shift_reg[BITS-2:0], sin_i};
          bit_next   = bit_reg + 4'h1;
          if (bit_reg == 4'(BITS - 1)) begin
            busy_next = 1'b0;
            done_next = 1'b1;
          end
        end
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
    end
    // a load during a transfer corrupts it; software must wait
    if (load_i) begin
      shift_next = load_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_reg <= '0;
      cnt_reg   <= 8'h00;
      bit_reg   <= 4'h0;
      busy_reg  <= 1'b0;
      sclk_reg  <= 1'b1;
      done_reg  <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      cnt_reg   <= cnt_next;
      bit_reg   <= bit_next;
      busy_reg  <= busy_next;
      sclk_reg  <= sclk_next;
      done_reg  <= done_next;
    end
  end

  assign shift_o = shift_reg;
  assign busy_o  = busy_reg;
  assign done_o  = done_reg;
  assign sclk_o  = sclk_reg;
  assign sout_o  = shift_reg[BITS-1];
endmodule : ioxe_serial

// ===== sim/ioxe_core_model.sv
`timescale 1ns/1ps
// accumulator and b register of the core; the bench preloads, the block writes back
module ioxe_core_model (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       load_i,
  input  wire logic [3:0] load_acc_i,
  input  wire logic [3:0] load_b_i,
  input  wire logic       acc_wr_i,
  input  wire logic [3:0] acc_data_i,
  input  wire logic       breg_wr_i,
  input  wire logic [3:0] breg_data_i,
  output logic [3:0]      acc_o,
  output logic [3:0]      breg_o
);
  logic [3:0] acc_reg;
  logic [3:0] acc_next;
  logic [3:0] b_reg;
  logic [3:0] b_next;
  // preload wins; the bench never preloads in a write-back cycle
  always_comb begin
    acc_next = load_i ? load_acc_i : (acc_wr_i ? acc_data_i : acc_reg);
    b_next   = load_i ? load_b_i : (breg_wr_i ? breg_data_i : b_reg);
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_reg <= 4'h0;
      b_reg   <= 4'h0;
    end else begin
      acc_reg <= acc_next;
      b_reg   <= b_next;
    end
  end
  assign acc_o  = acc_reg;
  assign breg_o = b_reg;
endmodule : ioxe_core_model

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import ioxe_pkg::*;
  logic ref_clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic pready_o, pslverr_o, instr_valid_i = 0, acc_wr_o, breg_wr_o, skip_o, err, ld = 0;
  logic [9:0] opcode_i = 10'h000;
  logic [3:0] acc_i, breg_i, interrupt_ctl_two_i = 4'h0, acc_data_o, breg_data_o, la, lb;
  logic [15:0] port_drive_cfg_o, key_wakeup_cfg_o;
  logic [11:0] pullup_cfg_o;
  logic [3:0] port_output_cfg_aux_o, serial_ctl_o, clock_mode_ctl_o;
  logic clock_source_ctl_o, rc_osc_sel_o, sclk_o, sout_o, sin_i, irq_o;
  int mismatches = 0, n_compared = 0;
  assign sin_i = sout_o; // loopback keeps the receive path busy
  ioxe_exec DUT (.ref_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .instr_valid_i, .opcode_i, .acc_i, .breg_i,
    .interrupt_ctl_two_i, .acc_wr_o, .acc_data_o, .breg_wr_o, .breg_data_o, .skip_o,
    .port_drive_cfg_o, .port_output_cfg_aux_o, .key_wakeup_cfg_o, .pullup_cfg_o,
    .serial_ctl_o, .clock_mode_ctl_o, .clock_source_ctl_o, .rc_osc_sel_o, .sclk_o,
    .sout_o, .sin_i, .irq_o);
  ioxe_core_model core (.ref_clk_i, .rst_n_i, .load_i(ld), .load_acc_i(la), .load_b_i(lb),
    .acc_wr_i(acc_wr_o), .acc_data_i(acc_data_o), .breg_wr_i(breg_wr_o),
    .breg_data_i(breg_data_o), .acc_o(acc_i), .breg_o(breg_i));
  always #5 ref_clk_i = ~ref_clk_i;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // apb master: request held until pready is seen high at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    #1;
  endtask : apb
  // preload acc and b, issue one instruction, then let the write-back land
  task ins(input logic [9:0] o, input logic [3:0] a, input logic [3:0] b, input logic sk);
    @(posedge ref_clk_i);
    ld <= 1;
    la <= a;
    lb <= b;
    @(posedge ref_clk_i);
    ld <= 0;
    instr_valid_i <= 1;
    opcode_i <= o;
    @(posedge ref_clk_i);
    instr_valid_i <= 0;
    #1;
    chk(skip_o, sk);
    @(posedge ref_clk_i);
    #1;
  endtask : ins
  task t_xfer;
    logic [9:0] wr[14] = '{OP_WR_DRIVE0, OP_WR_DRIVE1, OP_WR_DRIVE2, OP_WR_DRIVE3, OP_WR_AUX,
      OP_WR_KEY0, OP_WR_KEY1, OP_WR_KEY2, OP_WR_KEYX, OP_WR_PULL0, OP_WR_PULL1, OP_WR_PULL2,
      OP_WR_SERCTL, OP_WR_CLKMODE};
    logic [9:0] rds[9] = '{OP_RD_KEY0, OP_RD_KEY1, OP_RD_KEY2, OP_RD_KEYX, OP_RD_PULL0,
      OP_RD_PULL1, OP_RD_PULL2, OP_RD_SERCTL, OP_RD_CLKMODE};
    for (int i = 0; i < 14; i++) ins(wr[i], 4'(i + 1), 4'h0, 1'b0);
    chk(port_drive_cfg_o, 32'h4321);
    chk(port_output_cfg_aux_o, 32'h5);
    chk(key_wakeup_cfg_o, 32'h9876);
    chk(pullup_cfg_o, 32'hCBA);
    chk(serial_ctl_o, 32'hD);
    chk(clock_mode_ctl_o, 32'hE);
    for (int i = 0; i < 9; i++) begin
      ins(rds[i], 4'h0, 4'h0, 1'b0);
      chk(acc_i, 32'(i + 6));
    end
    $display("transfer test done");
  endtask : t_xfer
  task t_clk;
    chk(rc_osc_sel_o, 32'h0);
    ins(OP_WR_CLKSRC, 4'hE, 4'h0, 1'b0);
    chk(clock_source_ctl_o, 32'h0);
    ins(OP_WR_CLKSRC, 4'h1, 4'h0, 1'b0);
    chk(clock_source_ctl_o, 32'h1);
    ins(OP_RC_SELECT, 4'h0, 4'h0, 1'b0);
    chk(rc_osc_sel_o, 32'h1);
    apb(1'b0, 8'h1C, 32'h0);
    chk(err, 32'h1);
    apb(1'b0, ADDR_VIEW0, 32'h0);
    chk(rd, 32'h4321);
    apb(1'b0, ADDR_BITDIV, 32'h0);
    chk(rd, 32'(BITDIV_RESET));
    chk(sclk_o, 32'h1);
    $display("clock test done");
  endtask : t_clk
  task t_serial;
    int n;
    ins(OP_WR_SHIFT, 4'h5, 4'hA, 1'b0);
    apb(1'b0, ADDR_SHIFT, 32'h0);
    chk(rd[7:0], 32'hA5);
    ins(OP_RD_SHIFT, 4'h0, 4'h0, 1'b0);
    chk({breg_i, acc_i}, 32'hA5);
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    ins(OP_SER_START, 4'h0, 4'h0, 1'b0);
    apb(1'b0, ADDR_SHIFT, 32'h0);
    chk(rd[9:8], 32'h2);
    n = 0;
    while (rd[8] !== 1'b1 && n < 400) begin
      apb(1'b0, ADDR_SHIFT, 32'h0);
      n++;
    end
    chk(rd[8], 32'h1);
    chk(irq_o, 32'h1);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(rd[0], 32'h1);
    chk(irq_o, 32'h0);
    @(posedge ref_clk_i);
    interrupt_ctl_two_i <= 4'h8;
    ins(OP_SER_TEST, 4'h0, 4'h0, 1'b0);
    apb(1'b0, ADDR_SHIFT, 32'h0);
    chk(rd[8], 32'h1);
    @(posedge ref_clk_i);
    interrupt_ctl_two_i <= 4'h0;
    ins(OP_SER_TEST, 4'h0, 4'h0, 1'b1);
    ins(OP_WR_DRIVE0, 4'hF, 4'h0, 1'b0);
    chk(port_drive_cfg_o[3:0], 32'h1);
    apb(1'b0, ADDR_SHIFT, 32'h0);
    chk(rd[8], 32'h0);
    chk(irq_o, 32'h0);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(rd[1], 32'h1);
    $display("serial test done");
  endtask : t_serial
  // write then read of one pull-up register on back-to-back cycles
  task t_b2b;
    @(posedge ref_clk_i);
    ld <= 1;
    la <= 4'h3;
    lb <= 4'h0;
    @(posedge ref_clk_i);
    ld <= 0;
    instr_valid_i <= 1;
    opcode_i <= OP_WR_PULL1;
    @(posedge ref_clk_i);
    ld <= 1;
    la <= 4'h0;
    opcode_i <= OP_RD_PULL1;
    @(posedge ref_clk_i);
    ld <= 0;
    instr_valid_i <= 0;
    @(posedge ref_clk_i);
    #1;
    chk(pullup_cfg_o[7:4], 32'h3);
    chk(acc_i, 32'h3);
    $display("back-to-back test done");
  endtask : t_b2b
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1;
    t_xfer;
    t_clk;
    t_serial;
    t_b2b;
    summarize;
  end
  // whole run is well under 2000 cycles
  initial begin
    #200000;
    mismatches++;
    summarize;
  end
endmodule : testbench
